// ---- include/ibk_map.svh ----
// Register offsets, field positions and page numbers of the paged register space.
// Assumes byte-wide registers addressed by a 7-bit offset within the selected page.
`ifndef IBK_MAP_SVH
`define IBK_MAP_SVH

`define IBK_OFS_PAGE_SELECT 7'h00
`define IBK_OFS_BUF_HIGH 7'h01
`define IBK_OFS_BUF_LOW 7'h02
`define IBK_OFS_INSTR_FIRST 7'h02
`define IBK_OFS_INSTR_LAST 7'h61
`define IBK_RST_PAGE_SELECT 8'h00
`define IBK_PAGE_INSTR_BASE 8'h40
`define IBK_PAGE_INSTR_LAST 8'h5f
`define IBK_PAGE_BUFFER 8'hfc
`define IBK_INSTR_PER_PAGE 32
`define IBK_BYTES_PER_INSTR 3
`define IBK_INSTR_HI_MSB 23
`define IBK_INSTR_HI_LSB 16
`define IBK_INSTR_MID_MSB 15
`define IBK_INSTR_MID_LSB 8
`define IBK_INSTR_LO_MSB 7
`define IBK_INSTR_LO_LSB 0

`endif

// ---- include/ibk_pkg.sv ----
// Types shared by the instruction bank design files.
// Assumes ibk_map.svh is on the include path.
package ibk_pkg;

   // Which byte of a 24-bit instruction an offset touches
   typedef enum logic [1:0] {
      IBK_LANE_HIGH,
      IBK_LANE_MID,
      IBK_LANE_LOW
   } ibk_lane_t;

endpackage : ibk_pkg

// ---- hdl/ibk_instr_decode.sv ----
// Offset decoder for an instruction page: offset to slot and byte lane.
// Assumes the caller qualifies the result with the page number.
`timescale 1ns/1ps
`include "ibk_map.svh"

module ibk_instr_decode
   import ibk_pkg::*;
(
   input wire logic [6:0] offset,
   output logic hit,
   output logic [4:0] slot,
   output ibk_lane_t lane
);

   logic [6:0] rel;
   logic [6:0] slot_wide;
   logic [6:0] lane_wide;

   // ---------------------------------------------------------------
   // Triplet decode
   // ---------------------------------------------------------------
   assign hit = (offset >= `IBK_OFS_INSTR_FIRST) && (offset <= `IBK_OFS_INSTR_LAST);
   assign rel = offset - `IBK_OFS_INSTR_FIRST;
   assign slot_wide = rel / 7'(`IBK_BYTES_PER_INSTR);
   assign lane_wide = rel % 7'(`IBK_BYTES_PER_INSTR);
   assign slot = slot_wide[4:0];
   // First byte of a triplet is the top of the word
   assign lane = (lane_wide == 7'h00) ? IBK_LANE_HIGH :
                 (lane_wide == 7'h01) ? IBK_LANE_MID : IBK_LANE_LOW;

endmodule : ibk_instr_decode

// ---- hdl/ibk_bank.sv ----
// Paged register bank: playback engine instruction RAM and buffer readout page.
// Assumes a byte-wide register port, synchronous strobes, read data one cycle later.
//
// How it works
// - Pages 64-95 each hold 32 distinct instructions
// - Instruction memory spans indices 0 to 1023
// - Offset 0 page select, RW, resets zero
// - Offset 1 reads buffer word upper byte
// - Offset 2 reads buffer word lower byte as latched by the last offset 1 read
// - Instruction triplets occupy offsets 2 to 97
// - Triplet order: bits 23:16, 15:8, 7:0
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "ibk_map.svh"

module ibk_bank
   import ibk_pkg::*;
#(
   parameter int INSTR_COUNT = 1024,
   parameter int INSTR_WIDTH = 24,
   parameter int BUF_WIDTH = 16,
   parameter int PTR_WIDTH = 8
)
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Buffer side: the fill logic supplies the word at the read pointer
   input wire logic [BUF_WIDTH-1:0] buffer_word,
   output logic [PTR_WIDTH-1:0] buffer_read_pointer,
   // Engine side: instruction fetch port
   input wire logic [9:0] engine_addr,
   output logic [INSTR_WIDTH-1:0] engine_instr,
   output logic [7:0] page_select
);

   localparam int SLOT_BITS = $clog2(`IBK_INSTR_PER_PAGE);

   logic [7:0] page_select_reg;
   logic [7:0] rdata_reg;
   logic [7:0] held_low_reg;
   logic [PTR_WIDTH-1:0] ptr_reg;
   logic [INSTR_WIDTH-1:0] instr_mem [INSTR_COUNT];
   logic [INSTR_WIDTH-1:0] engine_instr_reg;

   logic instr_hit;
   logic [SLOT_BITS-1:0] slot;
   ibk_lane_t lane;
   logic on_instr_page;
   logic on_buffer_page;
   logic [7:0] page_rel;
   logic [9:0] instr_index;
   logic instr_access;
   logic wr_page_select;
   logic wr_instr;
   logic rd_high;
   logic rd_low;
   logic [INSTR_WIDTH-1:0] cur_instr;
   logic [7:0] instr_byte;
   logic [7:0] rdata_next;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   ibk_instr_decode u_decode (
      .offset(reg_addr),
      .hit(instr_hit),
      .slot(slot),
      .lane(lane)
   );

   assign on_instr_page = (page_select_reg >= `IBK_PAGE_INSTR_BASE) &&
                          (page_select_reg <= `IBK_PAGE_INSTR_LAST);
   assign on_buffer_page = (page_select_reg == `IBK_PAGE_BUFFER);
   assign page_rel = page_select_reg - `IBK_PAGE_INSTR_BASE;
   // Index = (page - 64) * 32 + slot; page 95 tops out at 1023
   assign instr_index = {page_rel[4:0], slot};
   assign instr_access = on_instr_page && instr_hit;

   // Page select lives at offset 0 of every page, so it is always reachable
   assign wr_page_select = reg_write && (reg_addr == `IBK_OFS_PAGE_SELECT);
   assign wr_instr = reg_write && instr_access;
   assign rd_high = reg_read && on_buffer_page && (reg_addr == `IBK_OFS_BUF_HIGH);
   assign rd_low = reg_read && on_buffer_page && (reg_addr == `IBK_OFS_BUF_LOW);

   assign cur_instr = instr_mem[instr_index];
   assign instr_byte = (lane == IBK_LANE_HIGH) ?
                          cur_instr[`IBK_INSTR_HI_MSB:`IBK_INSTR_HI_LSB] :
                       (lane == IBK_LANE_MID) ?
                          cur_instr[`IBK_INSTR_MID_MSB:`IBK_INSTR_MID_LSB] :
                          cur_instr[`IBK_INSTR_LO_MSB:`IBK_INSTR_LO_LSB];

   // ---------------------------------------------------------------
   // Read data select
   // ---------------------------------------------------------------
   // Reserved offsets (3-127 on the buffer page) read as zero; writes there are
   // dropped, which is harmless while the host writes only reset values.
   assign rdata_next = !reg_read ? 8'h00 :
                       (reg_addr == `IBK_OFS_PAGE_SELECT) ? page_select_reg :
                       rd_high ? buffer_word[BUF_WIDTH-1 -: 8] :
                       rd_low ? held_low_reg :
                       instr_access ? instr_byte :
                       8'h00;

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         page_select_reg <= `IBK_RST_PAGE_SELECT;
         rdata_reg <= 8'h00;
         held_low_reg <= 8'h00;
         ptr_reg <= '0;
      end else begin
         if (wr_page_select) begin
            page_select_reg <= reg_wdata;
         end
         rdata_reg <= rdata_next;
         // Latch the low byte with the high byte so a pair is one word
         if (rd_high) begin
            held_low_reg <= buffer_word[7:0];
         end
         // Advance only after the low byte so the pair stays coherent
         if (rd_low) begin
            ptr_reg <= ptr_reg + 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Instruction storage
   // ---------------------------------------------------------------
   // Contents are undefined after reset, so the array has no reset branch.
   always_ff @(posedge clk_sys) begin
      if (wr_instr) begin
         unique case (lane)
            IBK_LANE_HIGH: instr_mem[instr_index][`IBK_INSTR_HI_MSB:`IBK_INSTR_HI_LSB] <= reg_wdata;
            IBK_LANE_MID: instr_mem[instr_index][`IBK_INSTR_MID_MSB:`IBK_INSTR_MID_LSB] <= reg_wdata;
            IBK_LANE_LOW: instr_mem[instr_index][`IBK_INSTR_LO_MSB:`IBK_INSTR_LO_LSB] <= reg_wdata;
         endcase
      end
      engine_instr_reg <= instr_mem[engine_addr];
   end

   assign reg_rdata = rdata_reg;
   assign buffer_read_pointer = ptr_reg;
   assign engine_instr = engine_instr_reg;
   assign page_select = page_select_reg;

endmodule : ibk_bank

// ---- test/ibk_bank_monitor.sv ----
// Checker for ibk_bank: page select, buffer readout and read timing.
// Assumes default widths; it is bound to every ibk_bank instance.
`timescale 1ns/1ps
module ibk_bank_monitor (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic [15:0] buffer_word,
   input wire logic [7:0] buffer_read_pointer,
   input wire logic [7:0] page_select
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire buf_pg = page_select == 8'hfc;
   wire rd1 = reg_read && buf_pg && reg_addr == 7'h01;
   wire rd2 = reg_read && buf_pg && reg_addr == 7'h02;
   property p_sel_wr; reg_write && reg_addr == 7'h00 |=> page_select == $past(reg_wdata); endproperty
   a_sel_wr: assert property (p_sel_wr) else $error("select not written");
   property p_sel_keep; !(reg_write && reg_addr == 7'h00) |=> $stable(page_select); endproperty
   a_sel_keep: assert property (p_sel_keep) else $error("select moved");
   property p_hi; rd1 |=> reg_rdata == $past(buffer_word[15:8]); endproperty
   a_hi: assert property (p_hi) else $error("bad high byte");
   property p_lo; rd1 ##1 rd2 |=> reg_rdata == $past(buffer_word[7:0], 2); endproperty
   a_lo: assert property (p_lo) else $error("bad low byte");
   property p_ptr; rd2 |=> buffer_read_pointer == $past(buffer_read_pointer) + 8'h01; endproperty
   a_ptr: assert property (p_ptr) else $error("pointer not advanced");
   property p_idle; !reg_read |=> reg_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data outside slot");
   property p_rsv; reg_read && buf_pg && reg_addr > 7'h02 |=> reg_rdata == 8'h00; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved read not zero");
   property p_top; reg_read && page_select > 8'h5f && !buf_pg && reg_addr != 7'h00
      |=> reg_rdata == 8'h00; endproperty
   a_top: assert property (p_top) else $error("no page above last");
   cover property (rd1 ##1 rd2);
   cover property (reg_write && page_select == 8'h5f);
   cover property (reg_write && reg_addr == 7'h00);
endmodule : ibk_bank_monitor
bind ibk_bank ibk_bank_monitor ibk_bank_monitor_i (.*);

// ---- test/ibk_bank_test.sv ----
// Bench for ibk_bank: register port scenarios plus the fetch port.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
module ibk_bank_test;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [15:0] buffer_word = 16'h0000;
   logic [9:0] engine_addr = 10'h000;
   logic [7:0] reg_rdata, ptr, page_select;
   logic [23:0] engine_instr;
   int mismatches = 0;
   int samples_checked = 0;
   always #12.5 clk_sys = ~clk_sys;
   ibk_bank ibk_bank_i (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .buffer_word(buffer_word), .buffer_read_pointer(ptr), .engine_addr(engine_addr),
      .engine_instr(engine_instr), .page_select(page_select));
   task chk(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe, so look just past that edge
   task rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rd
   task t_instr(input logic [7:0] p, input logic [4:0] k);
      logic [6:0] o;
      logic [23:0] w;
      o = 7'h02 + 7'(k) * 7'h03;
      w = {p, ~p, 3'h5, k};
      wr(7'h00, p);
      wr(o, w[23:16]);
      wr(o + 7'h01, w[15:8]);
      wr(o + 7'h02, w[7:0]);
      rd(o, w[23:16]);
      rd(o + 7'h02, w[7:0]);
      @(posedge clk_sys);
      engine_addr <= 10'((int'(p) - 64) * 32 + int'(k));
      repeat (2) @(posedge clk_sys);
      #1 chk(engine_instr, w);
   endtask : t_instr
   // Buffer word changes right after the high read: the low byte must not follow it
   task t_buffer;
      wr(7'h00, 8'hfc);
      wr(7'h01, 8'h77);
      wr(7'h03, 8'h00);
      rd(7'h7f, 8'h00);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_sys);
         buffer_word <= {8'ha5, 8'hc3 + 8'(i)};
         reg_read <= 1'b1;
         reg_addr <= 7'h01;
         @(posedge clk_sys);
         reg_addr <= 7'h02;
         buffer_word <= 16'h0000;
         #1 chk(reg_rdata, 8'ha5);
         @(posedge clk_sys);
         reg_read <= 1'b0;
         #1 chk(reg_rdata, 8'hc3 + i);
         chk(ptr, i + 1);
      end
   endtask : t_buffer
   task wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      chk(page_select, 24'h0);
      rd(7'h00, 8'h00);
      for (int v = 15; v < 256; v = v * 2 + 1) begin
         wr(7'h00, 8'(v));
         rd(7'h00, 8'(v));
      end
      $display("select test done");
      t_instr(8'h40, 5'h00);
      t_instr(8'h41, 5'h1f);
      t_instr(8'h5f, 5'h1f);
      rd(7'h62, 8'h00);
      wr(7'h00, 8'h60);
      wr(7'h02, 8'h3c);
      rd(7'h02, 8'h00);
      $display("instruction test done");
      t_buffer();
      $display("buffer test done");
      wrap_up();
   end
endmodule : ibk_bank_test
